/* File: hdl/spc_pkg.sv */
// spc_pkg: constants and types of the strap configuration decoder
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package spc_pkg;
	// strap geometry
	localparam int SPC_PINS = 8;
	localparam int SPC_CODE_W = 4;
	localparam int BIT_TIE = 3;
	localparam int BIT_COMB = 2;
	localparam int PIN_MEDIA2 = 5;
	localparam int PIN_MEDIA1 = 4;
	localparam int PIN_MEDIA0 = 3;
	localparam int PIN_RATE = 4;
	localparam int PIN_REV = 2;
	localparam int PIN_ADDR4 = 1;
	localparam int PIN_ADDR3 = 0;
	// register byte offsets
	localparam int SPC_AW = 8;
	localparam logic [7:0] OFF_MEDIA = 8'h00;
	localparam logic [7:0] OFF_LED_CFG = 8'h04;
	localparam logic [7:0] OFF_LED_FUNC = 8'h08;
	localparam logic [7:0] OFF_ADDR = 8'h0C;
	localparam logic [7:0] OFF_RAW = 8'h10;
	// field positions
	localparam int MEDIA_AMS_BIT = 4;
	localparam int MEDIA_RSV_BIT = 5;
	localparam int LCFG_FC_BIT = 15;
	localparam int LCFG_RATE_LSB = 10;
	localparam int LFUNC_W = 4;
	localparam int ADDR_REV_BIT = 2;
	// media codes
	localparam logic [2:0] MEDIA_COPPER = 3'h0;
	localparam logic [2:0] MEDIA_SERDES = 3'h1;
	localparam logic [2:0] MEDIA_FIBER = 3'h2;
	localparam logic [2:0] MEDIA_AMS_SERDES = 3'h5;
	localparam logic [2:0] MEDIA_AMS_FIBER = 3'h6;
	// timing: millisecond tick, stretch per rate code, blink half is half of it
	localparam int CLK_PERIOD_PS = 10000;
	localparam longint TICK_PS = 64'd1000000000;
	localparam int TICK_CYC = int'(TICK_PS / CLK_PERIOD_PS);
	localparam int MS_W = 9;
	localparam logic [MS_W-1:0] STRETCH_MS [4] = '{9'h190, 9'h0C8, 9'h064, 9'h032};
	// link state seen by the indicator logic
	typedef struct packed {
		logic link10;
		logic link100;
		logic gigabitLinkState;
		logic fiberLink;
		logic activity;
		logic fiberActivity;
		logic fullDuplex;
		logic collision;
	} spc_linkStatus_type;
	typedef struct packed {
		logic [2:0] mediaSel;
		logic autoMedia;
		logic mediaReserved;
	} spc_media_type;
	typedef enum logic [1:0] {ST_SAMPLE = 2'b01, ST_RUN = 2'b10} spc_state_type;
endpackage

/* File: hdl/spc_strap_decoder.sv */
// spc_strap_decoder: strap capture, config registers on AHB-Lite, indicators
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module spc_strap_decoder import spc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC // cycles per millisecond tick
) (
	input wire logic sys_clk, // 100 MHz clock
	input wire logic nrst, // async reset, active low
	input wire logic [SPC_PINS-1:0][SPC_CODE_W-1:0] config_strap_pins, // decoded strap codes
	input wire logic hsel, // ahb select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response, always okay
	output logic [31:0] hrdata, // ahb read data
	input wire spc_linkStatus_type linkStatus, // port link state
	input wire logic [4:0] mgmtAddr, // management station address
	output logic addrHit, // address belongs to this device
	output logic [2:0] addrPort, // port for that address
	output spc_media_type mediaCfg, // media interface selection
	output logic [1:0] stationAddrUpperBits, // strapped address bits 4:3
	output logic portOrderReversal, // strapped reversal
	output logic indicatorA, // indicator a drive
	output logic indicatorB, // indicator b drive
	output logic indicatorC, // indicator c drive
	output logic indicatorD // indicator d drive
);
	// elaboration check: the millisecond divider below is only 24 bits wide
	if (TICK_CYCLES < 1 || TICK_CYCLES > 2**24) begin : g_tickCheck
		$error("TICK_CYCLES out of range");
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	spc_state_type stateQ, stateD;
	logic [2:0] mediaSelQ, mediaSelD;
	logic [15:0] ledCfgQ, ledCfgD;
	logic [15:0] ledFuncQ, ledFuncD;
	logic [1:0] addrUpQ, addrUpD;
	logic revQ, revD;
	logic [31:0] rawQ, rawD;
	logic wrPendQ, wrPendD;
	logic [SPC_AW-1:0] addrQ, addrD;
	logic take;

	// address phase taken only once straps are loaded
	assign take = hsel & htrans[1] & hready & (stateQ == ST_RUN);

	// strap load on first edge after reset release, then bus writes
	always_comb begin
		stateD = stateQ;
		mediaSelD = mediaSelQ;
		ledCfgD = ledCfgQ;
		ledFuncD = ledFuncQ;
		addrUpD = addrUpQ;
		revD = revQ;
		rawD = rawQ;
		wrPendD = take & hwrite;
		addrD = take ? haddr[SPC_AW-1:0] : addrQ;
		unique case (stateQ)
			ST_SAMPLE: begin
				stateD = ST_RUN;
				rawD = config_strap_pins;
				mediaSelD = {config_strap_pins[PIN_MEDIA2][BIT_TIE],
					config_strap_pins[PIN_MEDIA1][BIT_TIE],
					config_strap_pins[PIN_MEDIA0][BIT_TIE]};
				ledCfgD = '0;
				ledCfgD[LCFG_FC_BIT] = config_strap_pins[PIN_RATE][BIT_COMB];
				ledCfgD[LCFG_RATE_LSB +: 2] = config_strap_pins[PIN_RATE][1:0];
				ledFuncD = '0;
				for (int i = 0; i < 4; i++) begin
					ledCfgD[i] = config_strap_pins[i][BIT_COMB];
					ledFuncD[i*LFUNC_W +: 2] = config_strap_pins[i][1:0];
				end
				addrUpD = {config_strap_pins[PIN_ADDR4][BIT_TIE],
					config_strap_pins[PIN_ADDR3][BIT_TIE]};
				revD = config_strap_pins[PIN_REV][BIT_TIE];
			end
			ST_RUN: begin
				// address bits and reversal are strap only, never written
				if (wrPendQ) begin
					unique case (addrQ)
						OFF_MEDIA: mediaSelD = hwdata[2:0];
						OFF_LED_CFG: ledCfgD = hwdata[15:0];
						OFF_LED_FUNC: ledFuncD = hwdata[15:0];
						default: ;
					endcase
				end
			end
			default: stateD = ST_SAMPLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stateQ <= ST_SAMPLE;
			mediaSelQ <= MEDIA_COPPER;
			ledCfgQ <= '0;
			ledFuncQ <= '0;
			addrUpQ <= '0;
			revQ <= 1'b0;
			rawQ <= '0;
			wrPendQ <= 1'b0;
			addrQ <= '0;
		end else begin
			stateQ <= stateD;
			mediaSelQ <= mediaSelD;
			ledCfgQ <= ledCfgD;
			ledFuncQ <= ledFuncD;
			addrUpQ <= addrUpD;
			revQ <= revD;
			rawQ <= rawD;
			wrPendQ <= wrPendD;
			addrQ <= addrD;
		end
	end

	// ------------------------------------------------------------
	// bus answers and configuration outputs
	// ------------------------------------------------------------
	// zero wait once loaded; held low while straps are being taken
	assign hreadyout = (stateQ == ST_RUN);
	assign hresp = 1'b0;

	// read mux of flops; unmapped offsets read zero
	always_comb begin
		hrdata = '0;
		unique case (addrQ)
			OFF_MEDIA: begin
				hrdata[2:0] = mediaSelQ;
				hrdata[MEDIA_AMS_BIT] = mediaCfg.autoMedia;
				hrdata[MEDIA_RSV_BIT] = mediaCfg.mediaReserved;
			end
			OFF_LED_CFG: hrdata[15:0] = ledCfgQ;
			OFF_LED_FUNC: hrdata[15:0] = ledFuncQ;
			OFF_ADDR: hrdata[ADDR_REV_BIT:0] = {revQ, addrUpQ};
			OFF_RAW: hrdata = rawQ;
			default: ;
		endcase
	end

	// media decode, reserved codes flagged and passed through unchanged
	always_comb begin
		mediaCfg.mediaSel = mediaSelQ;
		mediaCfg.autoMedia = (mediaSelQ == MEDIA_AMS_SERDES) ||
			(mediaSelQ == MEDIA_AMS_FIBER);
		mediaCfg.mediaReserved = !(mediaCfg.autoMedia || mediaSelQ == MEDIA_COPPER ||
			mediaSelQ == MEDIA_SERDES || mediaSelQ == MEDIA_FIBER);
	end
	assign stationAddrUpperBits = addrUpQ;
	assign portOrderReversal = revQ;

	// ------------------------------------------------------------
	// address to port mapping
	// ------------------------------------------------------------
	logic addrHitQ, addrHitD;
	logic [2:0] addrPortQ, addrPortD;
	always_comb begin
		addrHitD = (mgmtAddr[4:3] == addrUpQ);
		addrPortD = revQ ? ~mgmtAddr[2:0] : mgmtAddr[2:0];
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addrHitQ <= 1'b0;
			addrPortQ <= '0;
		end else begin
			addrHitQ <= addrHitD;
			addrPortQ <= addrPortD;
		end
	end
	assign addrHit = addrHitQ;
	assign addrPort = addrPortQ;

	// ------------------------------------------------------------
	// blink and pulse stretch timing
	// ------------------------------------------------------------
	logic [23:0] tickCntQ, tickCntD;
	logic msTick;
	logic [MS_W-1:0] blinkCntQ, blinkCntD, stretchMs;
	logic blinkQ, blinkD;
	logic [MS_W-1:0] holdQ [2];
	logic [MS_W-1:0] holdD [2];
	logic [1:0] actIn, actS;

	assign msTick = (tickCntQ == 24'(TICK_CYCLES - 1));
	assign stretchMs = STRETCH_MS[ledCfgQ[LCFG_RATE_LSB +: 2]];
	assign actIn = {linkStatus.fiberActivity, linkStatus.activity};

	// activity is held for the stretch time; blink half period is half of it
	always_comb begin
		tickCntD = msTick ? '0 : tickCntQ + 24'h000001;
		blinkCntD = blinkCntQ;
		blinkD = blinkQ;
		if (msTick) begin
			if (blinkCntQ >= (stretchMs >> 1) - 9'h001) begin
				blinkCntD = '0;
				blinkD = ~blinkQ;
			end else begin
				blinkCntD = blinkCntQ + 9'h001;
			end
		end
		for (int i = 0; i < 2; i++) begin
			actS[i] = actIn[i] | (holdQ[i] != '0);
			if (actIn[i]) begin
				holdD[i] = stretchMs;
			end else if (msTick && holdQ[i] != '0) begin
				holdD[i] = holdQ[i] - 9'h001;
			end else begin
				holdD[i] = holdQ[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCntQ <= '0;
			blinkCntQ <= '0;
			blinkQ <= 1'b0;
			holdQ <= '{default: '0};
		end else begin
			tickCntQ <= tickCntD;
			blinkCntQ <= blinkCntD;
			blinkQ <= blinkD;
			holdQ <= holdD;
		end
	end

	// ------------------------------------------------------------
	// indicator functions
	// ------------------------------------------------------------
	// returns {status level, blink event}; codes above 3 are register-only and dark
	function automatic logic [1:0] spc_ledSel(input logic [1:0] idx, input logic [3:0] code,
		input logic [7:0] t);
		// t: fib1000,l100g,l10_100,anyLink,act,fibLnk,fibAct,l100 packed with events
		logic [1:0] r;
		r = 2'b00;
		if (code[3:2] == 2'b00) begin
			unique case ({idx, code[1:0]})
				4'h0: r = {t[7], t[3]}; // gigabit or fiber link, activity
				4'h1: r = {t[6], t[3]};
				4'h2: r = {t[3], t[3]}; // activity only
				4'h3: r = {t[4], t[3]}; // any link
				4'h4: r = {t[0], t[3]}; // 100 link
				4'h5: r = {t[6], t[3]};
				4'h6: r = {t[5], t[3]};
				4'h7: r = {t[2], t[1]}; // fiber link, fiber activity
				4'h8: r = {t[4], t[3]};
				4'h9: r = {2'b00}; // duplex filled in by caller
				4'hA: r = {t[1], t[1]}; // fiber activity only
				4'hB: r = {1'b0, t[3]}; // 10 link filled in by caller
				4'hC: r = 2'b00; // duplex filled in by caller
				4'hD: r = {t[0], t[3]};
				4'hE: r = {t[3], t[3]};
				4'hF: r = {t[2], t[1]};
			endcase
		end
		return r;
	endfunction

	logic [7:0] terms;
	logic [3:0] ledD, ledQ;
	logic fib, linkAny, actAny;
	always_comb begin
		fib = ~ledCfgQ[LCFG_FC_BIT] & linkStatus.fiberLink;
		linkAny = linkStatus.link10 | linkStatus.link100 | linkStatus.gigabitLinkState | fib;
		actAny = actS[0] | (~ledCfgQ[LCFG_FC_BIT] & actS[1]);
		terms = {linkStatus.gigabitLinkState | fib,
			linkStatus.link100 | linkStatus.gigabitLinkState | fib,
			linkStatus.link10 | linkStatus.link100, linkAny, actAny,
			linkStatus.fiberLink, actS[1], linkStatus.link100};
		for (int i = 0; i < 4; i++) begin
			logic [1:0] sel;
			logic [3:0] code;
			sel = 2'b00;
			code = ledFuncQ[i*LFUNC_W +: LFUNC_W];
			sel = spc_ledSel(2'(i), code, terms);
			if (code == 4'h0 && i == 3 || code == 4'h1 && i == 2) begin
				sel = {linkStatus.fullDuplex, linkStatus.collision};
			end
			if (code == 4'h3 && i == 2) begin
				sel[1] = linkStatus.link10;
			end
			// steady when combine bit set, else blink during the event
			ledD[i] = sel[1] & (ledCfgQ[i] | ~sel[0] | blinkQ);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ledQ <= '0;
		end else begin
			ledQ <= ledD;
		end
	end
	assign {indicatorD, indicatorC, indicatorB, indicatorA} = ledQ;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_rawLoad;
		stateQ == ST_SAMPLE |=> rawQ == $past(config_strap_pins);
	endproperty
	a_rawLoad: assert property (p_rawLoad) else $error("raw strap not captured");
	property p_rateLoad;
		stateQ == ST_SAMPLE |=> ledCfgQ[LCFG_RATE_LSB +: 2] == $past(config_strap_pins[PIN_RATE][1:0])
			&& ledCfgQ[LCFG_FC_BIT] == $past(config_strap_pins[PIN_RATE][BIT_COMB]);
	endproperty
	a_rateLoad: assert property (p_rateLoad) else $error("rate strap wrong");
	property p_mediaLoad;
		stateQ == ST_SAMPLE |=> mediaCfg.mediaSel == {$past(config_strap_pins[PIN_MEDIA2][BIT_TIE]),
			$past(config_strap_pins[PIN_MEDIA1][BIT_TIE]), $past(config_strap_pins[PIN_MEDIA0][BIT_TIE])};
	endproperty
	a_mediaLoad: assert property (p_mediaLoad) else $error("media strap wrong");
	property p_ams;
		mediaCfg.autoMedia == (mediaCfg.mediaSel inside {3'h5, 3'h6}) &&
			mediaCfg.mediaReserved == (mediaCfg.mediaSel inside {3'h3, 3'h4, 3'h7});
	endproperty
	a_ams: assert property (p_ams) else $error("media decode wrong");
	property p_addrLoad;
		stateQ == ST_SAMPLE |=> stationAddrUpperBits == {$past(config_strap_pins[1][3]),
			$past(config_strap_pins[0][3])} ##1 $stable(stationAddrUpperBits)[*8];
	endproperty
	a_addrLoad: assert property (p_addrLoad) else $error("address strap wrong");
	property p_portMap;
		1'b1 |=> addrPort == ($past(revQ) ? 3'h7 - $past(mgmtAddr[2:0]) : $past(mgmtAddr[2:0]));
	endproperty
	a_portMap: assert property (p_portMap) else $error("port map wrong");
	property p_mediaWrite;
		wrPendQ && addrQ == OFF_MEDIA && stateQ == ST_RUN |=> mediaCfg.mediaSel == $past(hwdata[2:0]);
	endproperty
	a_mediaWrite: assert property (p_mediaWrite) else $error("media write lost");
	property p_funcWrite;
		wrPendQ && addrQ == OFF_LED_FUNC && stateQ == ST_RUN |=> ledFuncQ == $past(hwdata[15:0]);
	endproperty
	a_funcWrite: assert property (p_funcWrite) else $error("function write lost");
	property p_ready;
		$rose(stateQ == ST_RUN) |-> hreadyout && $past(!hreadyout);
	endproperty
	a_ready: assert property (p_ready) else $error("bus ready before load");
	property p_steadyA;
		ledCfgQ[0] && ledFuncQ[3:0] == 4'h3 |=> indicatorA == $past(linkAny);
	endproperty
	a_steadyA: assert property (p_steadyA) else $error("indicator a not steady");
	property p_duplexD;
		ledCfgQ[3] && ledFuncQ[15:12] == 4'h0 |=> indicatorD == $past(linkStatus.fullDuplex);
	endproperty
	a_duplexD: assert property (p_duplexD) else $error("indicator d not duplex");
	property p_duplexC;
		ledCfgQ[2] && ledFuncQ[11:8] == 4'h1 |=> indicatorC == $past(linkStatus.fullDuplex);
	endproperty
	a_duplexC: assert property (p_duplexC) else $error("indicator c not duplex");
	property p_fiberB;
		ledCfgQ[1] && ledFuncQ[7:4] == 4'h3 |=> indicatorB == $past(linkStatus.fiberLink);
	endproperty
	a_fiberB: assert property (p_fiberB) else $error("indicator b not fiber");
	property p_gigA;
		ledCfgQ[0] && ledCfgQ[LCFG_FC_BIT] && ledFuncQ[3:0] == 4'h0
			|=> indicatorA == $past(linkStatus.gigabitLinkState);
	endproperty
	a_gigA: assert property (p_gigA) else $error("indicator a not gigabit");

	c_write: cover property (wrPendQ && addrQ == OFF_LED_CFG);
	c_readRaw: cover property (take && !hwrite && haddr[SPC_AW-1:0] == OFF_RAW);
	c_ams: cover property (mediaCfg.autoMedia);
	c_rev: cover property (revQ && addrHit);
endmodule

/* File: tb/spc_board_straps.sv */
// spc_board_straps: board strap resistors seen by the decoder
`timescale 1ns/1ps
module spc_board_straps import spc_pkg::*; (
	input wire logic [SPC_PINS-1:0] tieRail, // 1 = tied to supply
	input wire logic [SPC_PINS-1:0][2:0] resIdx, // resistor value index
	output logic [SPC_PINS-1:0][SPC_CODE_W-1:0] config_strap_pins // codes at the device
);
	// ----------------------------------------------------------------
	// strap code forming
	// ----------------------------------------------------------------
	// rail on top, resistor below; address and reversal pins formed the same way as the rest
	always_comb begin
		for (int n = 0; n < SPC_PINS; n++) begin
			config_strap_pins[n] = {tieRail[n], resIdx[n]};
		end
	end
endmodule

/* File: tb/tb_top.sv */
// tb_top: bus-level bench for the strap configuration decoder
`timescale 1ns/1ps
module tb_top import spc_pkg::*;;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic [7:0] tieRail = 8'h00;
	logic [7:0][2:0] resIdx = '0;
	logic [7:0][3:0] straps;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	spc_linkStatus_type linkStatus = '0;
	logic [4:0] mgmtAddr = 5'h00;
	logic addrHit;
	logic [2:0] addrPort;
	spc_media_type mediaCfg;
	logic [1:0] stationAddrUpperBits;
	logic portOrderReversal;
	logic indicatorA, indicatorB, indicatorC, indicatorD;
	logic [31:0] rdv;
	int err_total = 0;
	int checks = 0;

	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	spc_board_straps spc_board_straps_inst (
		.tieRail(tieRail),
		.resIdx(resIdx),
		.config_strap_pins(straps)
	);
	// short tick keeps the millisecond counts small
	spc_strap_decoder #(.TICK_CYCLES(4)) spc_strap_decoder_inst (
		.sys_clk(sys_clk), .nrst(nrst), .config_strap_pins(straps),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .linkStatus(linkStatus), .mgmtAddr(mgmtAddr), .addrHit(addrHit),
		.addrPort(addrPort), .mediaCfg(mediaCfg), .stationAddrUpperBits(stationAddrUpperBits),
		.portOrderReversal(portOrderReversal), .indicatorA(indicatorA),
		.indicatorB(indicatorB), .indicatorC(indicatorC), .indicatorD(indicatorD)
	);

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// whole run is a few thousand cycles; this is far beyond it
	initial begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one single word transfer; ready and read data are taken at the rising edge
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'h1) @(posedge sys_clk);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hreadyout !== 1'h1) @(posedge sys_clk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'h1, d, rdv);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(a, 1'h0, 32'h0, rdv);
		chk(rdv, exp);
	endtask
	// link state in, all four indicators compared one registered cycle later
	task automatic lnk(input logic [7:0] ls, input logic [31:0] expDCBA);
		linkStatus <= ls;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({28'h0, indicatorD, indicatorC, indicatorB, indicatorA}, expDCBA);
		@(posedge sys_clk);
	endtask
	// register image expected straight after load
	function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic [31:0] s);
		logic [2:0] m;
		m = {s[23], s[19], s[15]};
		case (a)
			OFF_MEDIA: return {26'h0, m == 3'h3 || m == 3'h4 || m == 3'h7,
				m == 3'h5 || m == 3'h6, 1'h0, m};
			OFF_LED_CFG: return {16'h0, s[18], 3'h0, s[17:16], 6'h0, s[14], s[10], s[6], s[2]};
			OFF_LED_FUNC: return {16'h0, 2'h0, s[13:12], 2'h0, s[9:8], 2'h0, s[5:4], 2'h0, s[1:0]};
			OFF_ADDR: return {29'h0, s[11], s[7], s[3]};
			OFF_RAW: return s;
			default: return 32'h0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] s;
		logic [31:0] e0;
		int nTog;
		logic bl;
		// every media code once, with rails and resistors varied alongside
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			nrst <= 1'h0;
			tieRail <= {i[0], i[1], i[2], i[1], i[0], i[0] ^ i[1], i[1], ~i[0]};
			for (int n = 0; n < 8; n++) resIdx[n] <= 3'(n + i);
			repeat (16) @(posedge sys_clk);
			chk({31'h0, hreadyout}, 32'h0);
			nrst <= 1'h1;
			@(negedge sys_clk);
			chk({31'h0, hreadyout}, 32'h0);
			@(negedge sys_clk);
			chk({31'h0, hreadyout}, 32'h1);
			s = straps;
			e0 = exp_reg(OFF_MEDIA, s);
			chk({27'h0, mediaCfg}, {27'h0, e0[2:0], e0[4], e0[5]});
			chk({30'h0, stationAddrUpperBits}, {30'h0, s[7], s[3]});
			chk({31'h0, portOrderReversal}, {31'h0, s[11]});
			@(posedge sys_clk);
			rdc(OFF_MEDIA, e0);
			rdc(OFF_LED_CFG, exp_reg(OFF_LED_CFG, s));
			rdc(OFF_LED_FUNC, exp_reg(OFF_LED_FUNC, s));
			rdc(OFF_ADDR, exp_reg(OFF_ADDR, s));
			rdc(OFF_RAW, s);
			// whole management address space against the strapped map
			for (int k = 0; k < 32; k++) begin
				mgmtAddr <= 5'(k);
				@(posedge sys_clk);
				@(negedge sys_clk);
				chk({31'h0, addrHit}, {31'h0, 2'(k >> 3) == {s[7], s[3]}});
				chk({29'h0, addrPort}, {29'h0, s[11] ? 3'h7 - 3'(k) : 3'(k)});
				@(posedge sys_clk);
			end
		end
		// software overrides; address straps stay read-only
		wr(OFF_MEDIA, 32'h5);
		rdc(OFF_MEDIA, 32'h15);
		chk({27'h0, mediaCfg}, 32'h16);
		wr(OFF_LED_CFG, 32'hFFFFFFFF);
		rdc(OFF_LED_CFG, 32'hFFFF);
		wr(OFF_LED_FUNC, 32'hFEDC);
		rdc(OFF_LED_FUNC, 32'hFEDC);
		wr(OFF_ADDR, 32'hFFFFFFFF);
		rdc(OFF_ADDR, exp_reg(OFF_ADDR, s));
		wr(OFF_RAW, 32'h0);
		rdc(OFF_RAW, s);
		wr(8'h14, 32'hFFFFFFFF);
		rdc(8'h14, 32'h0);
		// steady a and d, b and c on their default functions, copper only first
		wr(OFF_LED_CFG, 32'h8009);
		wr(OFF_LED_FUNC, 32'h3);
		lnk(8'h20, 32'h5);
		lnk(8'h12, 32'h8);
		wr(OFF_LED_CFG, 32'h0009);
		lnk(8'h10, 32'h5);
		wr(OFF_LED_FUNC, 32'h0);
		wr(OFF_LED_CFG, 32'h8009);
		lnk(8'h40, 32'h6);
		lnk(8'h20, 32'h5);
		// fastest rate: 50 ms stretch is 200 cycles of four-cycle ticks
		wr(OFF_LED_CFG, 32'h0C01);
		wr(OFF_LED_FUNC, 32'h0002);
		lnk(8'h08, 32'h1);
		lnk(8'h00, 32'h1);
		repeat (140) @(posedge sys_clk);
		chk({31'h0, indicatorA}, 32'h1);
		repeat (80) @(posedge sys_clk);
		chk({31'h0, indicatorA}, 32'h0);
		// blinking on activity: 25 ms half period, so ten changes in 1000 cycles
		wr(OFF_LED_CFG, 32'h0C00);
		linkStatus <= 8'h08;
		repeat (200) @(posedge sys_clk);
		nTog = 0;
		for (int k = 0; k < 1000; k++) begin
			bl = indicatorA;
			@(posedge sys_clk);
			if (indicatorA !== bl) nTog++;
		end
		chk(32'(nTog), 32'd10);
		linkStatus <= 8'h00;
		tally_and_finish();
	end
endmodule
